// ---- design/tlviu_pkg.sv ----
// constants, register map and state types of the two-level vectored interrupt unit
package tlviu_pkg;

    localparam int NUM_SOURCES = 23;
    localparam int IDX_W = 5;
    localparam int VEC_W = 16;
    localparam int NUM_BASIC = 7;
    localparam int SPI_ORDER = 6;
    localparam int SPI_FLAGS = 4;

    // wishbone byte offsets
    localparam logic [7:0] OFS_BASIC_ENABLE = 8'h00;
    localparam logic [7:0] OFS_EXT_ENABLE_A = 8'h04;
    localparam logic [7:0] OFS_EXT_ENABLE_B = 8'h08;
    localparam logic [7:0] OFS_BASIC_PRIO = 8'h0C;
    localparam logic [7:0] OFS_EXT_PRIO_A = 8'h10;
    localparam logic [7:0] OFS_EXT_PRIO_B = 8'h14;
    localparam logic [7:0] OFS_PENDING = 8'h18;
    localparam logic [7:0] OFS_SPI_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PRIO_UNUSED_BIT = 7;
    localparam int ST_REQ_BIT = 0;
    localparam int ST_INSVC_LO_BIT = 1;
    localparam int ST_INSVC_HI_BIT = 2;
    localparam int ST_CALL_BIT = 3;
    localparam int ST_GRACE_BIT = 4;
    localparam int ST_IDX_LSB = 8;
    localparam int ST_LVL_BIT = 13;

    // reset values
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [22:0] PENDING_RESET = 23'h00_0000;

    // sources whose flag is cleared by hardware when vectoring:
    // external a (0), timer a (1), external b (2), timer b (3), can (16)
    localparam logic [22:0] HW_CLEAR_MASK = 23'h01_000F;

    // vectors
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;

    // timing in system clock cycles
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam int RETURN_FROM_INTERRUPT_CYCLES = 5;
    localparam int DIV_CYCLES = 8;
    localparam int MIN_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
    localparam int MAX_RESPONSE = DETECT_CYCLES + RETURN_FROM_INTERRUPT_CYCLES + DIV_CYCLES + CALL_CYCLES;

    typedef enum logic [1:0] {
        TLV_IDLE = 2'b00,
        TLV_CALL = 2'b01
    } tlv_state_type;

endpackage

// ---- design/tlviu_top.sv ----
// two-level vectored interrupt unit with a classic wishbone register slave
// Summary of operation
// R1 - 23 sources, each low or high priority
// R2 - valid condition sets pending flag regardless enables
// R3 - disabled source flag makes no request
// R4 - finish instruction then long call to vector
// R5 - global enable bit seven gates all sources
// R6 - individual enables in three enable registers
// R7 - priority bit mirrors enable bit, 1 high
// R8 - clearing instruction then single-cycle may still vector
// R9 - software follows enable clear with two-byte opcode
// R10 - hardware clears externals, timers, can flag only
// R11 - flag still set after return re-requests immediately; the unit vectors only after one more instruction
// R12 - software-set flag behaves like hardware-set flag
// R13 - high preempts low, nothing preempts high
// R14 - higher level wins, then lowest order number
// R15 - equal or higher service holds off new request
// R16 - sampled every clock, five cycle minimum response
// R17 - eighteen cycle worst case after return and divide
// R18 - reset vector zero, order n at 3+8n
// R19 - four serial flags share order six request
// R20 - one in-service bit per priority level
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps

module tlviu_top #(
    parameter int NSRC = tlviu_pkg::NUM_SOURCES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [tlviu_pkg::NUM_SOURCES-1:0] src_set_i,
    input wire logic [tlviu_pkg::SPI_FLAGS-1:0] spi_set_i,
    input wire logic cpu_instr_done_i,
    input wire logic cpu_return_from_interrupt_i,
    input wire logic cpu_clears_enable_i,
    input wire logic cpu_next_multi_i,
    output logic irq_req_o,
    output logic call_active_o,
    output logic call_done_o,
    output logic [tlviu_pkg::VEC_W-1:0] vector_o,
    output logic call_level_o,
    output logic [1:0] in_service_o
);
    import tlviu_pkg::*;

    typedef struct packed {
        logic [7:0] basic_enable_reg;
        logic [7:0] extended_enable_reg_a;
        logic [7:0] extended_enable_reg_b;
        logic [6:0] basic_priority_reg;
        logic [7:0] extended_priority_reg_a;
        logic [7:0] extended_priority_reg_b;
        logic [22:0] pending;
        logic [3:0] spi_flags;
        logic [23:0] enable_snap;
        logic grace;
        logic [1:0] in_service;
        tlv_state_type state;
        logic [2:0] call_cnt;
        logic req;
        logic [4:0] req_idx;
        logic req_lvl;
        logic [15:0] vector;
        logic call_lvl;
        logic call_done;
        logic ack;
        logic [31:0] rdata;
    } tlviu_state_type;

    tlviu_state_type q_ff;
    tlviu_state_type nxt_q;

    // lowest set index wins inside one level
    function automatic logic [4:0] first_set(input logic [22:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] vector_of(input logic [4:0] order);
        return 16'(VECTOR_BASE + VECTOR_STEP * {11'h000, order});
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wd,
                                          input logic en);
        return en ? wd : old;
    endfunction

    logic [22:0] live_enable;
    logic [22:0] live_prio;
    logic [23:0] live_en_full;
    logic [23:0] eff_en_full;
    logic [22:0] pend_view;
    logic [22:0] active;
    logic [22:0] active_hi;
    logic [22:0] active_lo;
    logic can_hi;
    logic can_lo;
    logic bus_hit;
    logic [31:0] status_word;
    logic [22:0] pend_wr;
    logic [7:0] pend_top;
    logic take_call;

    always_comb begin
        live_enable = {q_ff.extended_enable_reg_b, q_ff.extended_enable_reg_a,
                       q_ff.basic_enable_reg[NUM_BASIC-1:0]}; // R6
        live_prio = {q_ff.extended_priority_reg_b, q_ff.extended_priority_reg_a,
                     q_ff.basic_priority_reg}; // R7
        live_en_full = {q_ff.basic_enable_reg[GLOBAL_EN_BIT], live_enable};
        // during the grace instruction the enables seen before the clear still count
        eff_en_full = q_ff.grace ? q_ff.enable_snap : live_en_full; // R8
        pend_view = q_ff.pending;
        pend_view[SPI_ORDER] = |q_ff.spi_flags; // R19
        // disabled sources and a cleared global bit yield nothing
        active = pend_view & eff_en_full[22:0] & {23{eff_en_full[23]}}; // R3 R5
        active_hi = active & live_prio;
        active_lo = active & ~live_prio;
        can_hi = (|active_hi) && !q_ff.in_service[1]; // R13 R15
        can_lo = (|active_lo) && (q_ff.in_service == 2'b00); // R13 R15
        bus_hit = wb_cyc_i && wb_stb_i && !q_ff.ack;
        take_call = (q_ff.state == TLV_IDLE) && q_ff.req && cpu_instr_done_i
                    && !cpu_return_from_interrupt_i; // R4 R11
        status_word = 32'h0000_0000;
        status_word[ST_REQ_BIT] = q_ff.req;
        status_word[ST_INSVC_LO_BIT] = q_ff.in_service[0];
        status_word[ST_INSVC_HI_BIT] = q_ff.in_service[1];
        status_word[ST_CALL_BIT] = (q_ff.state == TLV_CALL);
        status_word[ST_GRACE_BIT] = q_ff.grace;
        status_word[ST_IDX_LSB +: IDX_W] = q_ff.req_idx;
        status_word[ST_LVL_BIT] = q_ff.req_lvl;
        pend_top = merge8({1'b0, q_ff.pending[22:16]}, wb_dat_i[23:16], wb_sel_i[2]);
        pend_wr = {pend_top[6:0],
                   merge8(q_ff.pending[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                   merge8(q_ff.pending[7:0], wb_dat_i[7:0], wb_sel_i[0])};
    end

    always_comb begin
        nxt_q = q_ff;
        nxt_q.call_done = 1'b0;
        nxt_q.ack = bus_hit;
        nxt_q.rdata = 32'h0000_0000;

        // register writes, one cycle answer, unmapped addresses read zero
        if (bus_hit && wb_we_i) begin
            if (wb_adr_i == OFS_BASIC_ENABLE) begin
                nxt_q.basic_enable_reg = merge8(q_ff.basic_enable_reg, wb_dat_i[7:0],
                                                wb_sel_i[0]);
            end else if (wb_adr_i == OFS_EXT_ENABLE_A) begin
                nxt_q.extended_enable_reg_a = merge8(q_ff.extended_enable_reg_a,
                                                     wb_dat_i[7:0], wb_sel_i[0]);
            end else if (wb_adr_i == OFS_EXT_ENABLE_B) begin
                nxt_q.extended_enable_reg_b = merge8(q_ff.extended_enable_reg_b,
                                                     wb_dat_i[7:0], wb_sel_i[0]);
            end else if (wb_adr_i == OFS_BASIC_PRIO) begin
                if (wb_sel_i[0]) begin
                    nxt_q.basic_priority_reg = wb_dat_i[6:0];
                end
            end else if (wb_adr_i == OFS_EXT_PRIO_A) begin
                nxt_q.extended_priority_reg_a = merge8(q_ff.extended_priority_reg_a,
                                                       wb_dat_i[7:0], wb_sel_i[0]);
            end else if (wb_adr_i == OFS_EXT_PRIO_B) begin
                nxt_q.extended_priority_reg_b = merge8(q_ff.extended_priority_reg_b,
                                                       wb_dat_i[7:0], wb_sel_i[0]);
            end else if (wb_adr_i == OFS_PENDING) begin
                // writing a one simulates the source firing
                nxt_q.pending = pend_wr; // R12
                if (wb_sel_i[0]) begin
                    nxt_q.spi_flags[0] = wb_dat_i[SPI_ORDER]; // R12 R19
                end
            end else if (wb_adr_i == OFS_SPI_FLAGS) begin
                if (wb_sel_i[0]) begin
                    nxt_q.spi_flags = wb_dat_i[SPI_FLAGS-1:0];
                end
            end
        end

        if (bus_hit && !wb_we_i) begin
            if (wb_adr_i == OFS_BASIC_ENABLE) begin
                nxt_q.rdata = {24'h00_0000, q_ff.basic_enable_reg};
            end else if (wb_adr_i == OFS_EXT_ENABLE_A) begin
                nxt_q.rdata = {24'h00_0000, q_ff.extended_enable_reg_a};
            end else if (wb_adr_i == OFS_EXT_ENABLE_B) begin
                nxt_q.rdata = {24'h00_0000, q_ff.extended_enable_reg_b};
            end else if (wb_adr_i == OFS_BASIC_PRIO) begin
                nxt_q.rdata = {24'h00_0000, 1'b1, q_ff.basic_priority_reg};
            end else if (wb_adr_i == OFS_EXT_PRIO_A) begin
                nxt_q.rdata = {24'h00_0000, q_ff.extended_priority_reg_a};
            end else if (wb_adr_i == OFS_EXT_PRIO_B) begin
                nxt_q.rdata = {24'h00_0000, q_ff.extended_priority_reg_b};
            end else if (wb_adr_i == OFS_PENDING) begin
                nxt_q.rdata = {9'h000, pend_view};
            end else if (wb_adr_i == OFS_SPI_FLAGS) begin
                nxt_q.rdata = {28'h000_0000, q_ff.spi_flags};
            end else if (wb_adr_i == OFS_STATUS) begin
                nxt_q.rdata = status_word;
            end
        end

        // sampled and priority decoded every clock: this is the detect cycle
        nxt_q.req = can_hi || can_lo; // R16
        if (can_hi) begin
            nxt_q.req_idx = first_set(active_hi); // R14
            nxt_q.req_lvl = 1'b1; // R14
        end else begin
            nxt_q.req_idx = first_set(active_lo); // R14
            nxt_q.req_lvl = 1'b0;
        end

        // instruction boundary bookkeeping for the enable-clear window
        if (cpu_instr_done_i) begin
            if (cpu_clears_enable_i && !cpu_next_multi_i) begin
                nxt_q.grace = 1'b1; // R8
            end else begin
                nxt_q.grace = 1'b0;
                nxt_q.enable_snap = live_en_full;
            end
            if (cpu_clears_enable_i && cpu_next_multi_i) begin
                // a multi-cycle follower closes the window at once
                nxt_q.enable_snap = live_en_full; // R8 R9
            end
        end

        // return ends the innermost active level; the boundary it completes on
        // never vectors, so one more instruction runs first
        if (cpu_instr_done_i && cpu_return_from_interrupt_i) begin
            if (q_ff.in_service[1]) begin
                nxt_q.in_service[1] = 1'b0; // R20
            end else begin
                nxt_q.in_service[0] = 1'b0; // R20
            end
        end

        case (q_ff.state)
            TLV_IDLE: begin
                if (take_call) begin
                    nxt_q.state = TLV_CALL;
                    nxt_q.call_cnt = 3'(CALL_CYCLES - 1); // R16 R17
                    nxt_q.vector = vector_of(q_ff.req_idx); // R18
                    nxt_q.call_lvl = q_ff.req_lvl;
                    nxt_q.in_service[q_ff.req_lvl] = 1'b1; // R20 R13
                    nxt_q.grace = 1'b0;
                    nxt_q.enable_snap = live_en_full;
                    if (HW_CLEAR_MASK[q_ff.req_idx]) begin
                        nxt_q.pending[q_ff.req_idx] = 1'b0; // R10
                    end
                end
            end
            TLV_CALL: begin
                if (q_ff.call_cnt == 3'h0) begin
                    nxt_q.state = TLV_IDLE;
                    nxt_q.call_done = 1'b1; // R16
                end else begin
                    nxt_q.call_cnt = q_ff.call_cnt - 3'h1;
                end
            end
            default: begin
                nxt_q.state = TLV_IDLE;
            end
        endcase

        // a source event in the same cycle as any clear still lands
        nxt_q.pending = nxt_q.pending | src_set_i; // R2 R1
        nxt_q.pending[SPI_ORDER] = 1'b0;
        nxt_q.spi_flags = nxt_q.spi_flags | spi_set_i | {3'b000, src_set_i[SPI_ORDER]}; // R19
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff.basic_enable_reg <= ENABLE_RESET;
            q_ff.extended_enable_reg_a <= ENABLE_RESET;
            q_ff.extended_enable_reg_b <= ENABLE_RESET;
            q_ff.basic_priority_reg <= PRIO_RESET[6:0]; // R7
            q_ff.extended_priority_reg_a <= PRIO_RESET;
            q_ff.extended_priority_reg_b <= PRIO_RESET;
            q_ff.pending <= PENDING_RESET;
            q_ff.spi_flags <= 4'h0;
            q_ff.enable_snap <= 24'h00_0000;
            q_ff.grace <= 1'b0;
            q_ff.in_service <= 2'b00;
            q_ff.state <= TLV_IDLE;
            q_ff.call_cnt <= 3'h0;
            q_ff.req <= 1'b0;
            q_ff.req_idx <= 5'h00;
            q_ff.req_lvl <= 1'b0;
            q_ff.vector <= RESET_VECTOR; // R18
            q_ff.call_lvl <= 1'b0;
            q_ff.call_done <= 1'b0;
            q_ff.ack <= 1'b0;
            q_ff.rdata <= 32'h0000_0000;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign wb_dat_o = q_ff.rdata;
    assign wb_ack_o = q_ff.ack;
    assign irq_req_o = q_ff.req;
    // the call state is the only code with bit 0 set, so the flop drives the pin
    assign call_active_o = q_ff.state[0];
    assign call_done_o = q_ff.call_done;
    assign vector_o = q_ff.vector;
    assign call_level_o = q_ff.call_lvl;
    assign in_service_o = q_ff.in_service;

endmodule

// ---- testbench/tlviu_properties.sv ----
// port-level assertions for the two-level vectored interrupt unit
`timescale 1ns/1ps
module tlviu_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cpu_instr_done_i,
    input wire logic cpu_return_from_interrupt_i,
    input wire logic cpu_clears_enable_i,
    input wire logic irq_req_o,
    input wire logic call_active_o,
    input wire logic call_done_o,
    input wire logic [tlviu_pkg::VEC_W-1:0] vector_o,
    input wire logic call_level_o,
    input wire logic [1:0] in_service_o
);
    import tlviu_pkg::*;
    logic [1:0] insvc_ff;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // in-service state as it stood on the edge that launched a call
    always_ff @(posedge clk_i) begin
        insvc_ff <= in_service_o;
    end
    property p_ack_lat;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("bus request not acked in one cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
    property p_call_len;
        $rose(call_active_o) |-> call_active_o [*4] ##1 (!call_active_o && call_done_o);
    endproperty
    a_call_len: assert property (p_call_len) else $error("vector call not four cycles");
    property p_take;
        irq_req_o && cpu_instr_done_i && !cpu_return_from_interrupt_i && !cpu_clears_enable_i
            && !call_active_o && !call_done_o |=> call_active_o;
    endproperty
    a_take: assert property (p_take) else $error("request not taken at boundary");
    property p_return_from_interrupt_hold;
        cpu_instr_done_i && cpu_return_from_interrupt_i |=> !$rose(call_active_o);
    endproperty
    a_return_from_interrupt_hold: assert property (p_return_from_interrupt_hold) else $error("call right after return");
    property p_vec;
        $rose(call_active_o) |-> vector_o[2:0] == 3'b011 && vector_o <= 16'h00B3;
    endproperty
    a_vec: assert property (p_vec) else $error("vector off the 3+8n grid");
    property p_insvc;
        $rose(call_active_o) |-> in_service_o[call_level_o];
    endproperty
    a_insvc: assert property (p_insvc) else $error("in-service bit not set on call");
    property p_no_pre;
        $rose(call_active_o) |-> !insvc_ff[1] && (call_level_o || !insvc_ff[0]);
    endproperty
    a_no_pre: assert property (p_no_pre) else $error("illegal preemption");
endmodule

bind tlviu_top tlviu_checker tlviu_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .cpu_instr_done_i, .cpu_return_from_interrupt_i, .cpu_clears_enable_i, .irq_req_o,
    .call_active_o, .call_done_o, .vector_o, .call_level_o, .in_service_o);

// ---- testbench/tlviu_cpu_model.sv ----
// core sequencer model: instruction boundaries with their qualifiers
`timescale 1ns/1ps
module tlviu_cpu_model (
    input wire logic clk_i,
    output logic done_o,
    output logic return_from_interrupt_o,
    output logic clr_o,
    output logic multi_o
);
    initial begin
        done_o = 1'b0;
        return_from_interrupt_o = 1'b0;
        clr_o = 1'b0;
        multi_o = 1'b0;
    end
    // one instruction of len cycles; callers never overlap it with a vector call
    task automatic exec(input int len, input logic return_from_interrupt, input logic clr, input logic multi);
        repeat (len - 1) @(posedge clk_i);
        done_o <= 1'b1;
        return_from_interrupt_o <= return_from_interrupt;
        clr_o <= clr;
        // a two-byte follower of an enable clear shows up as multi-cycle
        multi_o <= multi;
        @(posedge clk_i);
        done_o <= 1'b0;
        return_from_interrupt_o <= 1'b0;
        clr_o <= 1'b0;
        multi_o <= 1'b0;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench: register bus, source flags and core boundaries
`timescale 1ns/1ps
module testbench;
    import tlviu_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [NUM_SOURCES-1:0] src_set_i = '0;
    logic [SPI_FLAGS-1:0] spi_set_i = '0;
    logic cpu_instr_done_i, cpu_return_from_interrupt_i, cpu_clears_enable_i, cpu_next_multi_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_req_o, call_active_o, call_done_o, call_level_o;
    logic [VEC_W-1:0] vector_o;
    logic [1:0] in_service_o;
    int fail_count = 0;
    int total_checks = 0;
    int n;
    tlviu_top tlviu_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_set_i, .spi_set_i, .cpu_instr_done_i,
        .cpu_return_from_interrupt_i, .cpu_clears_enable_i, .cpu_next_multi_i, .irq_req_o, .call_active_o,
        .call_done_o, .vector_o, .call_level_o, .in_service_o);
    tlviu_cpu_model cpu_inst (.clk_i(clk_i), .done_o(cpu_instr_done_i), .return_from_interrupt_o(cpu_return_from_interrupt_i),
        .clr_o(cpu_clears_enable_i), .multi_o(cpu_next_multi_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // every polling wait loop runs through here so a hang ends the run
    task automatic step(inout int k);
        @(posedge clk_i);
        k++;
        if (k > 40) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do step(k); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0000_0000, q);
        chk(q, exp);
    endtask
    // a call must start, carry this vector and level, then finish
    task automatic take(input logic [15:0] v, input logic l);
        int k;
        k = 0;
        while (call_active_o !== 1'b1) step(k);
        chk({16'h0000, vector_o}, {16'h0000, v});
        chk({31'h0, call_level_o}, {31'h0, l});
        while (call_done_o !== 1'b1) step(k);
    endtask
    task automatic nocall();
        repeat (3) @(posedge clk_i);
        chk({31'h0, call_active_o}, 32'h0000_0000);
    endtask
    // enable only source s (global on), high priority when hi
    task automatic cfg(input int s, input logic hi);
        logic [31:0] v;
        int b;
        for (int r = 0; r < 3; r++) begin
            b = (r == 0) ? 0 : 8 * r - 1;
            v = (s >= b && s < b + 7 + int'(r > 0)) ? 32'h0000_0001 << (s - b) : 32'h0000_0000;
            wr(OFS_BASIC_ENABLE + 8'(4 * r), v | ((r == 0) ? 32'h0000_0080 : 32'h0000_0000));
            wr(OFS_BASIC_PRIO + 8'(4 * r), hi ? v : 32'h0000_0000);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 9; a++) rdchk(8'(4 * a), (a == 3) ? 32'h0000_0080 : 32'h0000_0000);
        src_set_i <= 23'h00_0020;
        @(posedge clk_i);
        src_set_i <= '0;
        rdchk(OFS_PENDING, 32'h0000_0020);
        wr(OFS_BASIC_ENABLE, 32'h0000_0020);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        nocall();
        wr(OFS_BASIC_ENABLE, 32'h0000_00A0);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        take(16'h002B, 1'b0);
        rdchk(OFS_PENDING, 32'h0000_0020);
        n = 0;
        fork
            begin
                cpu_inst.exec(RETURN_FROM_INTERRUPT_CYCLES, 1'b1, 1'b0, 1'b0);
                cpu_inst.exec(DIV_CYCLES, 1'b0, 1'b0, 1'b0);
                take(16'h002B, 1'b0);
            end
            begin
                repeat (RETURN_FROM_INTERRUPT_CYCLES + 2) step(n);
                chk({31'h0, irq_req_o}, 32'h0000_0001);
                while (call_done_o !== 1'b1) step(n);
                chk(32'(n), 32'(MAX_RESPONSE));
            end
        join
        wr(OFS_PENDING, 32'h0000_0000);
        cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        for (int s = 0; s < NUM_SOURCES; s++) begin
            cfg(s, s[0]);
            wr(OFS_PENDING, 32'h0000_0001 << s);
            cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
            take(16'h0003 + 16'(8 * s), s[0]);
            rdchk(OFS_PENDING, (s inside {0, 1, 2, 3, 16}) ? 0 : 32'h0000_0001 << s);
            wr(OFS_PENDING, 32'h0000_0000);
            wr(OFS_SPI_FLAGS, 32'h0000_0000);
            cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        end
        wr(OFS_BASIC_ENABLE, 32'h0000_0084);
        wr(OFS_EXT_ENABLE_A, 32'h0000_0004);
        wr(OFS_PENDING, 32'h0000_0204);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        take(16'h0013, 1'b0);
        rdchk(OFS_STATUS, 32'h0000_0902);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        nocall();
        wr(OFS_EXT_PRIO_A, 32'h0000_0004);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        take(16'h004B, 1'b1);
        wr(OFS_BASIC_PRIO, 32'h0000_0001);
        wr(OFS_BASIC_ENABLE, 32'h0000_0085);
        wr(OFS_PENDING, 32'h0000_0201);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        nocall();
        wr(OFS_PENDING, 32'h0000_0000);
        cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        @(posedge clk_i);
        chk({30'h0, in_service_o}, 32'h0000_0000);
        cfg(6, 1'b0);
        for (int k = 0; k < SPI_FLAGS; k++) begin
            spi_set_i <= 4'h1 << k;
            @(posedge clk_i);
            spi_set_i <= '0;
            rdchk(OFS_PENDING, 32'h0000_0040);
            rdchk(OFS_SPI_FLAGS, 32'h0000_0001 << k);
            cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
            take(16'h0033, 1'b0);
            wr(OFS_SPI_FLAGS, 32'h0000_0000);
            cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        end
        cfg(0, 1'b0);
        n = 0;
        src_set_i <= 23'h00_0001;
        step(n);
        src_set_i <= '0;
        while (irq_req_o !== 1'b1) step(n);
        chk(32'(n), 32'h0000_0003);
        cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
        take(16'h0003, 1'b0);
        cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
        // request posted while an enable clear executes: single-cycle follower may vector
        for (int m = 0; m < 2; m++) begin
            wr(OFS_BASIC_ENABLE, 32'h0000_0081);
            cpu_inst.exec(1, 1'b0, 1'b0, 1'b0);
            wr(OFS_BASIC_ENABLE, 32'h0000_0001);
            src_set_i <= 23'h00_0001;
            @(posedge clk_i);
            src_set_i <= '0;
            cpu_inst.exec(1, 1'b0, 1'b1, m[0]);
            cpu_inst.exec(2, 1'b0, 1'b0, 1'b0);
            if (m == 0) begin
                take(VECTOR_BASE, 1'b0);
                cpu_inst.exec(1, 1'b1, 1'b0, 1'b0);
            end else begin
                nocall();
            end
        end
        final_report();
    end
endmodule
